// file: design/acc_adc_control.sv
// converter control: apb registers, sequencer, compare, result guard
// assumes the analog front end presents a signed over/under indication and a
// digitised level each conversion clock; inputs synchronous to core_clk
`timescale 1ns/1ps

// Functional notes
// - entering stop1 or stop2 disables the converter automatically
// - after deep stop all registers hold reset values; software reconfigures
// - config bit 7 selects low power, lowering max conversion clock
// - config bits 6:5 divide input clock; 00 is divide by one
// - config bit 4 selects long sample time when set
// - sampling lasts 3.5 conversion clocks short, 23.5 long
// - config bits 3:2 select resolution; 10 means 10-bit
// - config bits 1:0 select input clock; 00 is bus clock
// - trigger/compare bit 7 reads one while converting
// - trigger/compare bit 6 picks software (0) or hardware trigger (1)
// - bit 5 enables compare, bit 4 direction, threshold in compare pair
// - trigger/compare bits 3:2 read zero; software writes zero to 1:0
// - channel bit 7 done flag set by hardware, writes ignored
// - channel bit 6 enables interrupt, asserted while done flag set
// - channel bit 5 continuous; clear means one conversion per trigger
// - channel bits 4:0 select input channel
// - high byte read first; result held until low byte read
// - pin control bit set disables digital pin buffer and pullup
// - input at or above high reference gives full scale; at or below low gives zero
// - compare: direction set flags result >= value, clear flags result < value
module acc_adc_control (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        deep_stop,
  input  wire logic        alt_clk_tick,
  input  wire logic        async_clk_tick,
  input  wire logic        hw_trigger,
  input  wire logic        at_or_above_high_reference,
  input  wire logic        at_or_below_low_reference,
  input  wire logic        compare_bit_above,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             conversion_irq,
  output logic      [4:0]  active_channel,
  output logic             sample_switch_on,
  output logic      [9:0]  dac_trial_code,
  output logic             low_power_select,
  output logic [15:0]      pin_digital_disable
);

  logic [7:0]  clock_config_reg;
  logic [7:0]  trigger_compare_reg;
  logic [7:0]  channel_conv_reg;
  logic [9:0]  result_reg;
  logic [9:0]  compare_value_reg;
  logic [15:0] pin_ctrl_reg;
  logic        done_reg;
  logic        hold_reg;
  logic        hw_trig_prev_reg;
  logic        convert_pending_reg;
  logic [2:0]  div_cnt_reg;
  logic        bus_half_reg;
  logic [5:0]  sample_cnt_reg;
  logic [3:0]  step_cnt_reg;
  logic [9:0]  sar_reg;
  logic [9:0]  trial_bit_reg;
  acc_pkg::acc_state_e state_reg;

  logic        wr_en;
  logic        rd_en;
  logic        src_tick;
  logic        conv_clk_tick;
  logic        half_tick;
  logic [5:0]  sample_step;
  logic [2:0]  div_limit;
  logic        is_10bit;
  logic [3:0]  steps;
  logic        sw_start;
  logic        hw_start;
  logic        start;
  logic        finish;
  logic [9:0]  final_code;
  logic [9:0]  cmp_diff;
  logic        cmp_true;
  logic        do_transfer;
  logic        stop_conv;
  logic        clr;
  logic [7:0]  wbyte;

  // deep stop clears everything as a reset would
  assign clr   = rst | deep_stop;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // ---------- registers ----------
  always_ff @(posedge core_clk) begin
    if (clr) begin
      clock_config_reg <= acc_pkg::RST_CLOCK_CONFIG;
    end else if (wr_en && pstrb[0] && paddr[7:0] == acc_pkg::OFF_CLOCK_CONFIG) begin
      clock_config_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr) begin
      trigger_compare_reg <= acc_pkg::RST_TRIGGER_COMPARE;
    end else if (wr_en && pstrb[0] && paddr[7:0] == acc_pkg::OFF_TRIGGER_COMPARE) begin
      // only bits 6:4 store; 3:2 unimplemented, 1:0 reserved
      trigger_compare_reg <= {1'b0, pwdata[6:4], 4'h0};
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr) begin
      channel_conv_reg <= acc_pkg::RST_CHANNEL_CONV;
    end else if (wr_en && pstrb[0] && paddr[7:0] == acc_pkg::OFF_CHANNEL_CONV) begin
      channel_conv_reg <= {1'b0, pwdata[6:0]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr) begin
      compare_value_reg <= {2'b00, acc_pkg::RST_BYTE};
    end else if (wr_en && paddr[7:0] == acc_pkg::OFF_COMPARE_HIGH) begin
      compare_value_reg[9:8] <= wbyte[1:0];
    end else if (wr_en && paddr[7:0] == acc_pkg::OFF_COMPARE_LOW) begin
      compare_value_reg[7:0] <= wbyte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr) begin
      pin_ctrl_reg <= {acc_pkg::RST_BYTE, acc_pkg::RST_BYTE};
    end else if (wr_en && paddr[7:0] == acc_pkg::OFF_PIN_CTRL_LOW) begin
      pin_ctrl_reg[7:0] <= wbyte;
    end else if (wr_en && paddr[7:0] == acc_pkg::OFF_PIN_CTRL_HIGH) begin
      pin_ctrl_reg[15:8] <= wbyte;
    end
  end

  // one pin disable per control bit
  genvar gi;
  generate
    for (gi = 0; gi < acc_pkg::NUM_PINS; gi++) begin : g_pin
      assign pin_digital_disable[gi] = pin_ctrl_reg[gi];
    end
  endgenerate

  // ---------- read mux ----------
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr[7:0])
        acc_pkg::OFF_CLOCK_CONFIG:    prdata[7:0] = clock_config_reg;
        acc_pkg::OFF_TRIGGER_COMPARE:
          prdata[7:0] = {state_reg != acc_pkg::ACC_IDLE || convert_pending_reg,
                         trigger_compare_reg[6:4], 4'h0};
        acc_pkg::OFF_CHANNEL_CONV:    prdata[7:0] = {done_reg, channel_conv_reg[6:0]};
        acc_pkg::OFF_RESULT_HIGH:     prdata[7:0] = {6'h00, result_reg[9:8]};
        acc_pkg::OFF_RESULT_LOW:      prdata[7:0] = result_reg[7:0];
        acc_pkg::OFF_COMPARE_HIGH:    prdata[7:0] = {6'h00, compare_value_reg[9:8]};
        acc_pkg::OFF_COMPARE_LOW:     prdata[7:0] = compare_value_reg[7:0];
        acc_pkg::OFF_PIN_CTRL_LOW:    prdata[7:0] = pin_ctrl_reg[7:0];
        acc_pkg::OFF_PIN_CTRL_HIGH:   prdata[7:0] = pin_ctrl_reg[15:8];
        default:                      prdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------- conversion clock ----------
  always_comb begin
    unique case (clock_config_reg[acc_pkg::CFG_ICLK_HI:acc_pkg::CFG_ICLK_LO])
      acc_pkg::ICLK_BUS:      src_tick = 1'b1;
      acc_pkg::ICLK_BUS_DIV2: src_tick = bus_half_reg;
      acc_pkg::ICLK_ALT:      src_tick = alt_clk_tick;
      acc_pkg::ICLK_ASYNC:    src_tick = async_clk_tick;
    endcase
  end

  // divide ratio 1,2,4,8 as terminal count
  always_comb begin
    unique case (clock_config_reg[acc_pkg::CFG_DIV_HI:acc_pkg::CFG_DIV_LO])
      2'b00: div_limit = 3'h0;
      2'b01: div_limit = 3'h1;
      2'b10: div_limit = 3'h3;
      2'b11: div_limit = 3'h7;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (clr) begin
      bus_half_reg <= 1'b0;
    end else begin
      bus_half_reg <= ~bus_half_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clr || state_reg == acc_pkg::ACC_IDLE) begin
      div_cnt_reg <= 3'h0;
    end else if (src_tick) begin
      div_cnt_reg <= (div_cnt_reg >= div_limit) ? 3'h0 : div_cnt_reg + 3'h1;
    end
  end

  assign conv_clk_tick = src_tick && div_cnt_reg >= div_limit;

  // half period marks; an undivided clock counts two halves per tick
  assign half_tick   = conv_clk_tick
                       || (src_tick && div_limit != 3'h0 && div_cnt_reg == (div_limit >> 1));
  assign sample_step = (div_limit == 3'h0) ? 6'h02 : 6'h01;

  assign low_power_select = clock_config_reg[acc_pkg::CFG_LOW_POWER];

  // ---------- triggers ----------
  assign sw_start = ~trigger_compare_reg[acc_pkg::TC_HW_TRIGGER] && wr_en && pstrb[0]
                    && paddr[7:0] == acc_pkg::OFF_CHANNEL_CONV
                    && pwdata[4:0] != acc_pkg::CHAN_OFF;
  assign hw_start = trigger_compare_reg[acc_pkg::TC_HW_TRIGGER]
                    && hw_trigger && ~hw_trig_prev_reg;

  always_ff @(posedge core_clk) begin
    if (clr) begin
      hw_trig_prev_reg <= 1'b0;
    end else begin
      hw_trig_prev_reg <= hw_trigger;
    end
  end

  // channel write aborts a running conversion unless a start is pending; a result finishing that cycle still transfers
  assign stop_conv = wr_en && pstrb[0] && paddr[7:0] == acc_pkg::OFF_CHANNEL_CONV;

  always_ff @(posedge core_clk) begin
    if (clr) begin
      convert_pending_reg <= 1'b0;
    end else begin
      convert_pending_reg <= sw_start | hw_start;
    end
  end

  assign start = convert_pending_reg;

  // ---------- sequencer ----------
  assign is_10bit = clock_config_reg[acc_pkg::CFG_MODE_HI:acc_pkg::CFG_MODE_LO]
                    == acc_pkg::MODE_10BIT;
  assign steps    = is_10bit ? acc_pkg::STEPS_10 : acc_pkg::STEPS_8;
  assign finish   = state_reg == acc_pkg::ACC_CONVERT && conv_clk_tick && step_cnt_reg == 4'h1;

  always_ff @(posedge core_clk) begin
    if (clr) begin
      state_reg      <= acc_pkg::ACC_IDLE;
      sample_cnt_reg <= 6'h00;
      step_cnt_reg   <= 4'h0;
      sar_reg        <= 10'h000;
      trial_bit_reg  <= 10'h000;
    end else if (stop_conv && !start) begin
      state_reg <= acc_pkg::ACC_IDLE;
    end else begin
      unique case (state_reg)
        acc_pkg::ACC_IDLE: begin
          if (start) begin
            state_reg      <= acc_pkg::ACC_SAMPLE;
            sample_cnt_reg <= clock_config_reg[acc_pkg::CFG_LONG_SAMPLE]
                              ? acc_pkg::SAMPLE_LONG_HALF
                              : acc_pkg::SAMPLE_SHORT_HALF;
          end
        end
        acc_pkg::ACC_SAMPLE: begin
          // count down half conversion clocks
          if (half_tick) begin
            if (sample_cnt_reg <= sample_step) begin
              state_reg     <= acc_pkg::ACC_CONVERT;
              step_cnt_reg  <= steps;
              sar_reg       <= 10'h000;
              trial_bit_reg <= is_10bit ? 10'h200 : 10'h080;
            end else begin
              sample_cnt_reg <= sample_cnt_reg - sample_step;
            end
          end
        end
        acc_pkg::ACC_CONVERT: begin
          if (conv_clk_tick) begin
            if (compare_bit_above) begin
              sar_reg <= sar_reg | trial_bit_reg;
            end
            trial_bit_reg <= trial_bit_reg >> 1;
            step_cnt_reg  <= step_cnt_reg - 4'h1;
            if (step_cnt_reg == 4'h1) begin
              if (channel_conv_reg[acc_pkg::CC_CONTINUOUS]) begin
                state_reg      <= acc_pkg::ACC_SAMPLE;
                sample_cnt_reg <= clock_config_reg[acc_pkg::CFG_LONG_SAMPLE]
                                  ? acc_pkg::SAMPLE_LONG_HALF
                                  : acc_pkg::SAMPLE_SHORT_HALF;
              end else begin
                state_reg <= acc_pkg::ACC_IDLE;
              end
            end
          end
        end
        default: state_reg <= acc_pkg::ACC_IDLE;
      endcase
    end
  end

  assign active_channel   = channel_conv_reg[acc_pkg::CC_CHAN_HI:acc_pkg::CC_CHAN_LO];
  assign sample_switch_on = state_reg == acc_pkg::ACC_SAMPLE;
  assign dac_trial_code   = sar_reg | trial_bit_reg;

  // ---------- result, clamp, compare ----------
  always_comb begin
    final_code = sar_reg | (compare_bit_above ? trial_bit_reg : 10'h000);
    if (at_or_above_high_reference) begin
      final_code = is_10bit ? acc_pkg::FULL_10 : acc_pkg::FULL_8;
    end else if (at_or_below_low_reference) begin
      final_code = acc_pkg::ZERO;
    end
  end

  assign cmp_diff = final_code - compare_value_reg;
  assign cmp_true = trigger_compare_reg[acc_pkg::TC_CMP_DIR]
                    ? (final_code >= compare_value_reg)
                    : (final_code < compare_value_reg);
  assign do_transfer = finish && !hold_reg
                       && (!trigger_compare_reg[acc_pkg::TC_CMP_ENABLE] || cmp_true);

  always_ff @(posedge core_clk) begin
    if (clr) begin
      result_reg <= 10'h000;
    end else if (do_transfer) begin
      result_reg <= trigger_compare_reg[acc_pkg::TC_CMP_ENABLE] ? cmp_diff : final_code;
    end
  end

  // high-byte read locks result until low-byte read
  always_ff @(posedge core_clk) begin
    if (clr) begin
      hold_reg <= 1'b0;
    end else if (rd_en && paddr[7:0] == acc_pkg::OFF_RESULT_LOW) begin
      hold_reg <= 1'b0;
    end else if (rd_en && paddr[7:0] == acc_pkg::OFF_RESULT_HIGH) begin
      hold_reg <= 1'b1;
    end
  end

  // done flag: set wins over clear
  always_ff @(posedge core_clk) begin
    if (clr) begin
      done_reg <= 1'b0;
    end else if (do_transfer) begin
      done_reg <= 1'b1;
    end else if (stop_conv || (rd_en && paddr[7:0] == acc_pkg::OFF_RESULT_LOW)) begin
      done_reg <= 1'b0;
    end
  end

  assign conversion_irq = done_reg & channel_conv_reg[acc_pkg::CC_IRQ_EN];

endmodule

// file: design/acc_pkg.sv
// package for the converter control block: register map, fields, timing
// assumes an apb master with 32-bit data and one aligned word per register
package acc_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CLOCK_CONFIG    = 8'h00;
  localparam logic [7:0] OFF_TRIGGER_COMPARE = 8'h04;
  localparam logic [7:0] OFF_CHANNEL_CONV    = 8'h08;
  localparam logic [7:0] OFF_RESULT_HIGH     = 8'h0c;
  localparam logic [7:0] OFF_RESULT_LOW      = 8'h10;
  localparam logic [7:0] OFF_COMPARE_HIGH    = 8'h14;
  localparam logic [7:0] OFF_COMPARE_LOW     = 8'h18;
  localparam logic [7:0] OFF_PIN_CTRL_LOW    = 8'h1c;
  localparam logic [7:0] OFF_PIN_CTRL_HIGH   = 8'h20;

  // reset values
  localparam logic [7:0] RST_CLOCK_CONFIG    = 8'h00;
  localparam logic [7:0] RST_TRIGGER_COMPARE = 8'h00;
  localparam logic [7:0] RST_CHANNEL_CONV    = 8'h1f;
  localparam logic [7:0] RST_BYTE            = 8'h00;

  // clock config fields
  localparam int CFG_LOW_POWER    = 7;
  localparam int CFG_DIV_HI       = 6;
  localparam int CFG_DIV_LO       = 5;
  localparam int CFG_LONG_SAMPLE  = 4;
  localparam int CFG_MODE_HI      = 3;
  localparam int CFG_MODE_LO      = 2;
  localparam int CFG_ICLK_HI      = 1;
  localparam int CFG_ICLK_LO      = 0;

  // trigger/compare fields
  localparam int TC_ACTIVE        = 7;
  localparam int TC_HW_TRIGGER    = 6;
  localparam int TC_CMP_ENABLE    = 5;
  localparam int TC_CMP_DIR       = 4;
  localparam int TC_RSVD_HI       = 1;
  localparam int TC_RSVD_LO       = 0;

  // channel/conversion fields
  localparam int CC_DONE          = 7;
  localparam int CC_IRQ_EN        = 6;
  localparam int CC_CONTINUOUS    = 5;
  localparam int CC_CHAN_HI       = 4;
  localparam int CC_CHAN_LO       = 0;

  // resolution codes
  localparam logic [1:0] MODE_8BIT  = 2'b00;
  localparam logic [1:0] MODE_12BIT = 2'b01;
  localparam logic [1:0] MODE_10BIT = 2'b10;

  // input clock sources
  localparam logic [1:0] ICLK_BUS      = 2'b00;
  localparam logic [1:0] ICLK_BUS_DIV2 = 2'b01;
  localparam logic [1:0] ICLK_ALT      = 2'b10;
  localparam logic [1:0] ICLK_ASYNC    = 2'b11;

  // sample window in half conversion clock cycles: 3.5 and 23.5 cycles
  localparam logic [5:0] SAMPLE_SHORT_HALF = 6'h07;
  localparam logic [5:0] SAMPLE_LONG_HALF  = 6'h2f;

  // approximation steps per resolution
  localparam logic [3:0] STEPS_8  = 4'h8;
  localparam logic [3:0] STEPS_10 = 4'ha;

  localparam logic [9:0] FULL_10 = 10'h3ff;
  localparam logic [9:0] FULL_8  = 10'h0ff;
  localparam logic [9:0] ZERO    = 10'h000;

  localparam int NUM_PINS = 16;
  localparam logic [4:0] CHAN_OFF = 5'h1f;

  typedef enum logic [1:0] {
    ACC_IDLE   = 2'b00,
    ACC_SAMPLE = 2'b01,
    ACC_CONVERT = 2'b10
  } acc_state_e;

endpackage

// file: verification/acc_adc_assertions.sv
// concurrent checks on the converter control block ports
// bound into acc_adc_control; sees only its ports
`timescale 1ns/1ps
module acc_adc_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        deep_stop,
  input wire logic [31:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        conversion_irq,
  input wire logic [4:0]  active_channel,
  input wire logic        sample_switch_on,
  input wire logic        low_power_select,
  input wire logic [15:0] pin_digital_disable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic acc_wr;
  logic acc_rd;
  assign acc_wr = psel && penable && pwrite;
  assign acc_rd = psel && penable && !pwrite;
  a_stop_idle: assert property (deep_stop |=> !sample_switch_on && !conversion_irq)
    else $error("converter still busy after deep stop");
  a_stop_regs: assert property (deep_stop |=> active_channel == 5'h1f
    && pin_digital_disable == 16'h0000 && !low_power_select)
    else $error("registers not at reset after deep stop");
  a_low_power: assert property (acc_wr && paddr[7:0] == 8'h00
    |=> low_power_select == $past(pwdata[7]))
    else $error("low power output does not follow config bit 7");
  a_chan_field: assert property (acc_wr && paddr[7:0] == 8'h08
    |=> active_channel == $past(pwdata[4:0]))
    else $error("channel output does not follow channel field");
  a_pin_ctl: assert property (acc_wr && paddr[7:0] == 8'h20
    |=> pin_digital_disable[15:8] == $past(pwdata[7:0]))
    else $error("pin disable bits do not follow pin control write");
  a_tc_zero: assert property (acc_rd && paddr[7:0] == 8'h04 |-> prdata[3:2] == 2'b00)
    else $error("unimplemented trigger bits read nonzero");
  a_active_rd: assert property (acc_rd && paddr[7:0] == 8'h04 && sample_switch_on
    |-> prdata[7])
    else $error("active flag low while sampling");
  a_irq_flag: assert property (acc_rd && paddr[7:0] == 8'h08
    |-> (prdata[7] && prdata[6]) == conversion_irq)
    else $error("irq does not match done and enable");
  a_irq_fall: assert property ($fell(conversion_irq)
    |-> $past(psel && penable) || $past(deep_stop) || $past(rst))
    else $error("done irq cleared without software action");
  c_sample: cover property ($rose(sample_switch_on));
  c_irq: cover property ($rose(conversion_irq));
  c_stop: cover property (deep_stop ##1 !deep_stop);
endmodule

bind acc_adc_control acc_adc_checker u_chk (
  .core_clk(core_clk), .rst(rst), .deep_stop(deep_stop), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .conversion_irq(conversion_irq), .active_channel(active_channel),
  .sample_switch_on(sample_switch_on), .low_power_select(low_power_select),
  .pin_digital_disable(pin_digital_disable)
);

// file: verification/adc_control_and_config_regs_bench.sv
// self-checking bench for the converter control block over apb
// clamp and comparator inputs stand in for the analog side
`timescale 1ns/1ps
module adc_control_and_config_regs_bench;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        deep_stop = 1'b0;
  logic        alt_tick = 1'b0;
  logic        async_tick = 1'b0;
  logic        hw_trig = 1'b0;
  logic        hi = 1'b0;
  logic        lo = 1'b0;
  logic        cb = 1'b0;
  logic [31:0] paddr = '0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        irq;
  logic        samp;
  logic        lp;
  logic [4:0]  act;
  logic [15:0] pins;
  logic [9:0]  dac;
  logic        slverr;
  logic [7:0]  rd_q;
  logic [7:0]  q;
  logic [7:0]  hb;
  logic [9:0]  r;
  logic [15:0] r16;
  logic [9:0]  exp_q[$];
  logic [7:0]  cfgs[7] = '{8'h98, 8'h08, 8'h00, 8'h68, 8'h4a, 8'h0b, 8'h25};
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int run = 0;
  int samp_len = 0;
  int dur[7];

  acc_adc_control u_dut (
    .core_clk(core_clk), .rst(rst), .deep_stop(deep_stop), .alt_clk_tick(alt_tick),
    .async_clk_tick(async_tick), .hw_trigger(hw_trig), .at_or_above_high_reference(hi),
    .at_or_below_low_reference(lo), .compare_bit_above(cb), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(slverr), .conversion_irq(irq), .active_channel(act),
    .sample_switch_on(samp), .dac_trial_code(dac), .low_power_select(lp),
    .pin_digital_disable(pins)
  );

  always #2.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    alt_tick <= ($urandom % 3) == 0;
    async_tick <= ($urandom % 4) == 0;
    if (psel && penable && !pwrite && pready) begin
      rd_q <= prdata[7:0];
    end
    if (samp) begin
      run <= run + 1;
    end else begin
      if (run != 0) begin
        samp_len <= run;
      end
      run <= 0;
    end
    if (cyc == 60000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge core_clk);
    paddr <= {24'h0, a};
    pwrite <= w;
    pwdata <= {24'h0, d};
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge core_clk);
    q = rd_q;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(a, 1'b0, 8'h00);
  endtask

  task automatic poll(input logic [7:0] a, input logic want);
    int t;
    t = 0;
    do begin
      rd(a);
      t++;
    end while (q[7] !== want && t < 400);
  endtask

  task automatic analog(input logic h, input logic l, input logic c);
    @(posedge core_clk);
    hi <= h;
    lo <= l;
    cb <= c;
  endtask

  task automatic get_res();
    rd(8'h0c);
    hb = q;
    rd(8'h10);
    r = {hb[1:0], q};
  endtask

  task automatic check_resets();
    for (int a = 0; a <= 36; a += 4) begin
      rd(8'(a));
      check(16'(q), (a == 8) ? 16'h001f : 16'h0000);
    end
  endtask

  function automatic logic [9:0] model(input logic [7:0] cfg, input logic h, input logic l,
                                       input logic c);
    logic [9:0] full;
    full = (cfg[3:2] == acc_pkg::MODE_10BIT) ? acc_pkg::FULL_10 : acc_pkg::FULL_8;
    if (h) return full;
    if (l) return acc_pkg::ZERO;
    return c ? full : acc_pkg::ZERO;
  endfunction

  task automatic conv(input int i);
    logic [7:0] cfg;
    logic [1:0] k;
    logic [4:0] ch;
    logic       c;
    cfg = cfgs[i];
    k = 2'($urandom % 3);
    ch = 5'($urandom % 16);
    c = 1'($urandom);
    wr(8'h00, cfg);
    rd(8'h00);
    check(16'(q), 16'(cfg));
    check(16'(lp), 16'(cfg[7]));
    wr(8'h04, 8'h0c);
    rd(8'h04);
    check(16'(q), 16'h0000);
    analog(k == 0, k == 1, c);
    exp_q.push_back(model(cfg, k == 0, k == 1, c));
    dur[i] = cyc;
    // bit 7 written high must not reach the done flag
    wr(8'h08, {3'b110, ch});
    check(16'(act), 16'(ch));
    rd(8'h04);
    check(16'(q[7]), 16'h0001);
    rd(8'h08);
    check(16'(q), 16'({3'b010, ch}));
    poll(8'h08, 1'b1);
    dur[i] = cyc - dur[i];
    check(16'(irq), 16'h0001);
    check(16'(dac), 16'(model(cfg, 1'b0, 1'b0, c)));
    get_res();
    check(16'(r), 16'(exp_q.pop_front()));
    check(16'(irq), 16'h0000);
    rd(8'h04);
    check(16'(q[7]), 16'h0000);
    if (cfg[6:5] == 2'b00 && cfg[1:0] == 2'b00) begin
      check(16'(cfg[4] ? samp_len inside {23, 24} : samp_len inside {3, 4}), 16'h1);
    end
  endtask

  initial begin
    void'($urandom(32'h350c233e));
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    check_resets();
    wr(8'h40, 8'hff);
    rd(8'h40);
    check(16'(q), 16'h0000);
    check(16'(slverr), 16'h0000);
    for (int i = 0; i < 7; i++) conv(i);
    check(16'(dur[3] > 4 * dur[1]), 16'h0001);
    wr(8'h00, 8'h08);
    analog(1'b1, 1'b0, 1'b0);
    wr(8'h08, 8'h04);
    poll(8'h08, 1'b1);
    rd(8'h0c);
    check(16'(q), 16'h0003);
    analog(1'b0, 1'b1, 1'b0);
    wr(8'h08, 8'h04);
    poll(8'h04, 1'b0);
    rd(8'h08);
    check(16'(q[7]), 16'h0000);
    rd(8'h10);
    check(16'(q), 16'h00ff);
    wr(8'h14, 8'h02);
    wr(8'h18, 8'h00);
    for (int j = 0; j < 4; j++) begin
      wr(8'h04, j[0] ? 8'h20 : 8'h30);
      analog(j < 2, j >= 2, 1'b0);
      wr(8'h08, 8'h05);
      poll(8'h04, 1'b0);
      rd(8'h08);
      check(16'(q[7]), 16'(j == 0 || j == 3));
      if (q[7] === 1'b1) begin
        get_res();
        check(16'(r), (j == 0) ? 16'h01ff : 16'h0200);
      end
    end
    wr(8'h04, 8'h40);
    analog(1'b1, 1'b0, 1'b0);
    wr(8'h08, 8'h42);
    rd(8'h04);
    check(16'(q[7]), 16'h0000);
    @(posedge core_clk);
    hw_trig <= 1'b1;
    repeat (3) @(posedge core_clk);
    hw_trig <= 1'b0;
    poll(8'h08, 1'b1);
    check(16'(q[7]), 16'h0001);
    get_res();
    check(16'(r), 16'h03ff);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h23);
    for (int j = 0; j < 2; j++) begin
      poll(8'h08, 1'b1);
      check(16'(q[7]), 16'h0001);
      get_res();
      check(16'(r), 16'h03ff);
    end
    r16 = 16'($urandom);
    wr(8'h1c, r16[7:0]);
    wr(8'h20, r16[15:8]);
    check(pins, r16);
    wr(8'h00, 8'h98);
    @(posedge core_clk);
    deep_stop <= 1'b1;
    @(posedge core_clk);
    deep_stop <= 1'b0;
    @(negedge core_clk);
    check(16'({samp, irq, lp}), 16'h0000);
    check(pins, 16'h0000);
    check_resets();
    tally_and_finish();
  end
endmodule
